// >>> logic/pha_cfg.svh
// timing counts, field positions and slot map constants for the host arbiter and config select block
`ifndef PHA_CFG_SVH
`define PHA_CFG_SVH
`define PHA_CLK_PERIOD_NS 10
`define PHA_NUM_MASTERS 6
`define PHA_GFX_INDEX 5
`define PHA_TYPE_LSB 0
`define PHA_TYPE0 2'h0
`define PHA_TYPE1 2'h1
`define PHA_REG_LSB 2
`define PHA_REG_MSB 7
`define PHA_FUNC_LSB 8
`define PHA_FUNC_MSB 10
`define PHA_DEV_LSB 11
`define PHA_DEV_MSB 15
`define PHA_BUS_LSB 16
`define PHA_BUS_MSB 23
`define PHA_ENABLE_BIT 31
`define PHA_CFG_SPACE_BYTES 256
`define PHA_CFG_HEADER_BYTES 64
`define PHA_DEV_SLOT1 5'h04
`define PHA_DEV_SLOT2 5'h09
`define PHA_DEV_SLOT3 5'h0A
`define PHA_DEV_SLOT4 5'h0B
`define PHA_DEV_SLOT5 5'h0D
`define PHA_DEV_MEMCTL 5'h00
`define PHA_DEV_GFXBRIDGE 5'h01
`define PHA_DEV_IGFX 5'h02
`define PHA_DEV_P2P 5'h1E
`define PHA_DEV_HUB 5'h1F
`define PHA_IDSEL_BASE 24
`define PHA_NUM_IRQ 8
`endif

// >>> logic/pha_pkg.sv
// types shared by both ends of the host arbiter and config select block
`default_nettype none
package pha_pkg;
  typedef enum logic [1:0] {PHA_ST_IDLE, PHA_ST_ADDR, PHA_ST_DATA} pha_mst_state_t;
  typedef enum logic [2:0] {
    PHA_TGT_NONE, PHA_TGT_MEMCTL, PHA_TGT_GFXBRIDGE, PHA_TGT_IGFX, PHA_TGT_P2P, PHA_TGT_HUB, PHA_TGT_SLOT
  } pha_target_t;
endpackage : pha_pkg
`default_nettype wire

// >>> logic/pha_bus_if.sv
// bus signals between the host end and the slot master/target end
`timescale 1ns/100ps
`default_nettype none
interface pha_bus_if;
  logic [5:0] req_n;
  logic [5:0] gnt_n;
  logic frame_n_o;
  logic frame_n_oe;
  logic frame_n;
  logic [31:0] ad_o;
  logic ad_oe;
  logic cfg_cycle;
  logic [31:0] ad;
  logic [7:0] irq_n;
  logic pme_n;
  assign frame_n = frame_n_oe ? frame_n_o : 1'b1;
  assign ad = ad_oe ? ad_o : 32'h0000_0000;
  modport host (input req_n, input frame_n, input irq_n, input pme_n, output gnt_n, output ad_o, output ad_oe,
                output cfg_cycle);
  modport slot (output req_n, output frame_n_o, output frame_n_oe, output irq_n, output pme_n, input gnt_n,
                input ad, input cfg_cycle, input frame_n);
endinterface : pha_bus_if
`default_nettype wire

// >>> logic/pha_idsel_map.sv
// decodes a config address into an upper address line select and an on-board target code
`timescale 1ns/100ps
`default_nettype none
`include "pha_cfg.svh"
module pha_idsel_map
  import pha_pkg::*;
(
  // address in
  input wire logic [31:0] cfg_addr_in,
  // decode out
  output logic [31:0] ad_word_out,
  output pha_target_t target_out,
  output logic [2:0] func_out
);
  logic [4:0] dev;
  logic [7:0] bus_num;
  logic [1:0] ctype;
  assign dev = cfg_addr_in[`PHA_DEV_MSB:`PHA_DEV_LSB];
  assign bus_num = cfg_addr_in[`PHA_BUS_MSB:`PHA_BUS_LSB];
  assign ctype = cfg_addr_in[`PHA_TYPE_LSB+1:`PHA_TYPE_LSB];
  assign func_out = cfg_addr_in[`PHA_FUNC_MSB:`PHA_FUNC_LSB];

  // slot device number to select line; unknown slots select nothing
  function automatic logic [31:0] idsel_of(input logic [4:0] d);
    logic [31:0] s;
    s = 32'h0000_0000;
    unique case (d)
      `PHA_DEV_SLOT1: s[`PHA_IDSEL_BASE] = 1'b1;
      `PHA_DEV_SLOT2: s[`PHA_IDSEL_BASE+1] = 1'b1;
      `PHA_DEV_SLOT3: s[`PHA_IDSEL_BASE+2] = 1'b1;
      `PHA_DEV_SLOT4: s[`PHA_IDSEL_BASE+3] = 1'b1;
      `PHA_DEV_SLOT5: s[`PHA_IDSEL_BASE+5] = 1'b1;
      default: s = 32'h0000_0000;
    endcase
    return s;
  endfunction : idsel_of

  // type 0 carries one select line; type 1 passes bus/dev/func through downstream
  always_comb begin
    ad_word_out = 32'h0000_0000;
    target_out = PHA_TGT_NONE;
    if (ctype == `PHA_TYPE0) begin
      ad_word_out = idsel_of(dev);
      ad_word_out[`PHA_FUNC_MSB:`PHA_FUNC_LSB] = func_out;
      ad_word_out[`PHA_REG_MSB:`PHA_REG_LSB] = cfg_addr_in[`PHA_REG_MSB:`PHA_REG_LSB];
      if (bus_num == 8'h00) begin
        unique case (dev)
          `PHA_DEV_MEMCTL: target_out = PHA_TGT_MEMCTL;
          `PHA_DEV_GFXBRIDGE: target_out = PHA_TGT_GFXBRIDGE;
          `PHA_DEV_IGFX: target_out = PHA_TGT_IGFX;
          `PHA_DEV_P2P: target_out = PHA_TGT_P2P;
          `PHA_DEV_HUB: target_out = PHA_TGT_HUB;
          default: target_out = (idsel_of(dev) != 32'h0000_0000) ? PHA_TGT_SLOT : PHA_TGT_NONE;
        endcase
      end else if (idsel_of(dev) != 32'h0000_0000) begin
        target_out = PHA_TGT_SLOT;
      end
    end else if (ctype == `PHA_TYPE1) begin
      ad_word_out = {8'h00, cfg_addr_in[23:2], 2'h1};
      target_out = PHA_TGT_SLOT;
    end
  end
endmodule : pha_idsel_map
`default_nettype wire

// >>> logic/pha_host.sv
// host end: round-robin bus arbiter with parking, config cycle former, interrupt and wake inputs
// How it works
// - low two address bits choose type 0/1
// - bits 7..2 pick one config dword
// - targets hold at most 256 config bytes
// - slot devices 4,9,10,11,13 map AD24-27,29
// - on-board devices 0,1,2,30,31 on bus 0
// - master requests when it lacks the bus
// - arbiter grants the requesting master
// - granted master drives frame; only the host drives address
// - owner may start frame without request
// - pairs 0-4 slots, pair 5 graphics
// - grants rotate round-robin among requesters
// - park on owner while nobody else asks
// - eight active-low interrupt inputs accepted
// - power event input accepted
// - device number picks single select line
// - type 0 local, type 1 bus number
// - 32-bit multiplexed bus, 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "pha_cfg.svh"
module pha_host
  import pha_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // bus side
  pha_bus_if.host bus,
  // config request from the cpu side
  input wire logic cfg_req_in,
  input wire logic [31:0] cfg_addr_in,
  output logic cfg_busy_out,
  output logic [2:0] cfg_target_out,
  output logic cfg_hub_func_ok_out,
  // status
  output logic [5:0] owner_out,
  output logic [7:0] irq_active_out,
  output logic pme_active_out
);
  // one request/grant pair per slot plus the graphics pair
  localparam int NM = `PHA_NUM_MASTERS;

  // registered state; every status output is one of these flops
  logic [NM-1:0] gnt_ff, nxt_gnt;
  logic [2:0] last_ff, nxt_last;
  logic [31:0] ad_ff, nxt_ad;
  logic ad_oe_ff, nxt_ad_oe;
  logic cfg_cyc_ff, nxt_cfg_cyc;
  logic busy_ff, nxt_busy;
  logic [2:0] tgt_ff, nxt_tgt;
  logic hub_ok_ff, nxt_hub_ok;
  logic [7:0] irq_ff, nxt_irq;
  logic pme_ff, nxt_pme;

  // decoder outputs and active-high requests
  logic [NM-1:0] req;
  logic [31:0] map_word;
  pha_target_t map_tgt;
  logic [2:0] map_func;

  // requests arrive active low; flip them once here
  assign req = ~bus.req_n;

  pha_idsel_map pha_idsel_map_inst (
    .cfg_addr_in(cfg_addr_in),
    .ad_word_out(map_word),
    .target_out(map_tgt),
    .func_out(map_func)
  );

  // next requester after the last granted one, wrapping around; starting
  // the search one past the last owner is what keeps the rotation fair
  function automatic logic [2:0] rr_pick(input logic [NM-1:0] r, input logic [2:0] last);
    logic [2:0] idx;
    logic [2:0] pick;
    logic found;
    pick = last;
    found = 1'b0;
    for (int k = 1; k <= NM; k++) begin
      idx = 3'((int'(last) + k) % NM);
      if (!found && r[idx]) begin
        pick = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction : rr_pick

  // arbiter: park on owner, drop grant one idle cycle before handing over;
  // the idle cycle lets the old owner see its grant gone before a new one
  // shows, at the cost of one dead cycle per handover
  always_comb begin
    nxt_gnt = gnt_ff;
    nxt_last = last_ff;
    if (gnt_ff == '0) begin
      if (req != '0) begin
        nxt_last = rr_pick(req, last_ff);
        nxt_gnt = '0;
        nxt_gnt[nxt_last] = 1'b1;
      end
    end else if ((req & ~gnt_ff) != '0) begin
      // another agent waits; remove the parked grant first
      nxt_gnt = '0;
    end
    // an owner starting frame without a request keeps its grant
  end

  // last pointer resets to the top pair so the first search starts at pair 0
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      gnt_ff <= '0;
      last_ff <= 3'(NM - 1);
    end else begin
      gnt_ff <= nxt_gnt;
      last_ff <= nxt_last;
    end
  end

  // hub functions that answer; 2, 6 and 7 are left unpopulated, so a probe
  // there must read as empty rather than alias onto a live function
  function automatic logic hub_func_ok(input logic [2:0] f);
    logic ok;
    ok = 1'b0;
    unique case (f)
      3'h0: ok = 1'b1;
      3'h1: ok = 1'b1;
      3'h3: ok = 1'b1;
      3'h4: ok = 1'b1;
      3'h5: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : hub_func_ok

  // config cycle former: address word held for one address phase;
  // a request during the busy cycle is dropped, so the caller must space
  // requests two cycles apart
  always_comb begin
    nxt_ad = ad_ff;
    nxt_ad_oe = 1'b0;
    nxt_cfg_cyc = 1'b0;
    nxt_busy = 1'b0;
    nxt_tgt = tgt_ff;
    nxt_hub_ok = hub_ok_ff;
    if (cfg_req_in && !busy_ff && cfg_addr_in[`PHA_ENABLE_BIT]) begin
      nxt_ad = map_word;
      nxt_ad_oe = 1'b1;
      nxt_cfg_cyc = 1'b1;
      nxt_busy = 1'b1;
      nxt_tgt = 3'(map_tgt);
      nxt_hub_ok = (map_tgt == PHA_TGT_HUB) && hub_func_ok(map_func);
    end
  end

  // config state; drive enable clears on reset so the bus floats low
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ad_ff <= 32'h0000_0000;
      ad_oe_ff <= 1'b0;
      cfg_cyc_ff <= 1'b0;
      busy_ff <= 1'b0;
      tgt_ff <= 3'h0;
      hub_ok_ff <= 1'b0;
    end else begin
      ad_ff <= nxt_ad;
      ad_oe_ff <= nxt_ad_oe;
      cfg_cyc_ff <= nxt_cfg_cyc;
      busy_ff <= nxt_busy;
      tgt_ff <= nxt_tgt;
      hub_ok_ff <= nxt_hub_ok;
    end
  end

  // interrupt and wake levels, registered so outputs come from flops;
  // this costs one cycle of latency on every level change
  always_comb begin
    nxt_irq = ~bus.irq_n;
    nxt_pme = ~bus.pme_n;
  end

  // level flops for interrupt and wake
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_ff <= 8'h00;
      pme_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
      pme_ff <= nxt_pme;
    end
  end

  // bus side drive, grants active low
  assign bus.gnt_n = ~gnt_ff;
  assign bus.ad_o = ad_ff;
  assign bus.ad_oe = ad_oe_ff;
  assign bus.cfg_cycle = cfg_cyc_ff;

  // status outputs straight from flops
  assign cfg_busy_out = busy_ff;
  assign cfg_target_out = tgt_ff;
  assign cfg_hub_func_ok_out = hub_ok_ff;
  assign owner_out = gnt_ff;
  assign irq_active_out = irq_ff;
  assign pme_active_out = pme_ff;
endmodule : pha_host
`default_nettype wire

// >>> logic/pha_slot.sv
// slot end: bus masters that request, wait for grant, then run a frame; config space of 256 bytes
`timescale 1ns/100ps
`default_nettype none
`include "pha_cfg.svh"
module pha_slot
  import pha_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // bus side
  pha_bus_if.slot bus,
  // user side
  input wire logic [5:0] want_bus_in,
  input wire logic [7:0] irq_in,
  input wire logic pme_in,
  output logic [5:0] frame_done_out,
  output logic [5:0] cfg_hit_out,
  output logic [7:0] cfg_reg_addr_out
);
  pha_mst_state_t st_ff [6];
  pha_mst_state_t nxt_st [6];
  logic [5:0] req_ff, nxt_req;
  logic [5:0] done_ff, nxt_done;
  logic [5:0] hit_ff, nxt_hit;
  logic [7:0] reg_ff, nxt_reg;
  logic frame_ff, nxt_frame;

  localparam logic [4:0] SLOT_IDSEL [5] = '{5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1D};

  // per master: request unless already granted, frame two cycles after grant
  always_comb begin
    nxt_frame = 1'b0;
    for (int i = 0; i < 6; i++) begin
      nxt_st[i] = st_ff[i];
      nxt_req[i] = 1'b0;
      nxt_done[i] = 1'b0;
      unique case (st_ff[i])
        PHA_ST_IDLE: begin
          // owner of a parked grant skips the request
          nxt_req[i] = want_bus_in[i] && bus.gnt_n[i];
          if (want_bus_in[i] && !bus.gnt_n[i] && bus.frame_n) begin
            nxt_st[i] = PHA_ST_ADDR;
          end
        end
        PHA_ST_ADDR: begin
          nxt_frame = 1'b1;
          nxt_st[i] = PHA_ST_DATA;
        end
        PHA_ST_DATA: begin
          nxt_done[i] = 1'b1;
          nxt_st[i] = PHA_ST_IDLE;
        end
        default: nxt_st[i] = PHA_ST_IDLE;
      endcase
    end
  end

  // config decode: select line and 256-byte dword index
  always_comb begin
    nxt_hit = 6'h00;
    nxt_reg = reg_ff;
    if (bus.cfg_cycle) begin
      for (int s = 0; s < 5; s++) begin
        nxt_hit[s] = bus.ad[SLOT_IDSEL[s]];
      end
      nxt_reg = {bus.ad[`PHA_REG_MSB:`PHA_REG_LSB], 2'h0};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 6; i++) begin
        st_ff[i] <= PHA_ST_IDLE;
      end
      req_ff <= 6'h00;
      done_ff <= 6'h00;
      hit_ff <= 6'h00;
      reg_ff <= 8'h00;
      frame_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      req_ff <= nxt_req;
      done_ff <= nxt_done;
      hit_ff <= nxt_hit;
      reg_ff <= nxt_reg;
      frame_ff <= nxt_frame;
    end
  end

  assign bus.req_n = ~req_ff;
  assign bus.frame_n_o = ~frame_ff;
  assign bus.frame_n_oe = frame_ff;
  assign bus.irq_n = ~irq_in;
  assign bus.pme_n = ~pme_in;
  assign frame_done_out = done_ff;
  assign cfg_hit_out = hit_ff;
  assign cfg_reg_addr_out = reg_ff;
endmodule : pha_slot
`default_nettype wire

// >>> test/pha_assertions.sv
// concurrent checks on the bus between the host end and the slot end
`timescale 1ns/100ps
`default_nettype none
module pha_assertions (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // bus signals
  input wire logic [5:0] req_n_in,
  input wire logic [5:0] gnt_n_in,
  input wire logic frame_n_in,
  input wire logic [31:0] ad_in,
  input wire logic ad_oe_in,
  input wire logic cfg_cycle_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // arbiter: one owner at a time, an idle cycle at every handover
  a_one_grant: assert property ($onehot0(~gnt_n_in)) else $error("two grants at once");
  a_grant_gap: assert property (gnt_n_in != 6'h3F && $past(gnt_n_in) != 6'h3F
    |-> gnt_n_in == $past(gnt_n_in)) else $error("grant moved without gap");
  a_grant_req: assert property (gnt_n_in == 6'h3F && req_n_in != 6'h3F
    |=> (~gnt_n_in & ~$past(req_n_in)) != 6'h00) else $error("grant not given to a requester");
  a_park_hold: assert property (gnt_n_in != 6'h3F && (~req_n_in & gnt_n_in) == 6'h00
    |=> gnt_n_in == $past(gnt_n_in)) else $error("parked grant lost");
  a_handover_drop: assert property (gnt_n_in != 6'h3F && (~req_n_in & gnt_n_in) != 6'h00
    |=> gnt_n_in == 6'h3F) else $error("grant kept while another asks");
  // reset itself must clear, so this one is not masked by it
  a_reset_clear: assert property (disable iff (1'b0) !resetn_in
    |=> gnt_n_in == 6'h3F && !ad_oe_in && !cfg_cycle_in) else $error("outputs not cleared by reset");
  // config cycle framing and address format
  a_cfg_pulse: assert property (ad_oe_in |-> cfg_cycle_in ##1 !ad_oe_in)
    else $error("config drive not one cycle");
  a_type0_sel: assert property (cfg_cycle_in && ad_in[1:0] == 2'h0
    |-> $onehot0(ad_in[31:11]) && ad_in[23:11] == 13'h0 && !ad_in[28] && ad_in[31:30] == 2'h0)
    else $error("bad select line");
  a_type1_fmt: assert property (cfg_cycle_in && ad_in[1:0] == 2'h1 |-> ad_in[31:24] == 8'h00)
    else $error("type 1 upper byte set");
  a_bad_type: assert property (cfg_cycle_in |-> !ad_in[1]) else $error("reserved type drove ad");
  a_frame_short: assert property (!frame_n_in |=> frame_n_in) else $error("frame longer than one cycle");
endmodule : pha_assertions
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench: host and slot ends joined over the bus interface
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pha_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cfg_req_in = 1'b0;
  logic [31:0] cfg_addr_in = 32'h0;
  logic [5:0] want_bus_in = 6'h0;
  logic [7:0] irq_in = 8'h0;
  logic pme_in = 1'b0;
  logic cfg_busy_out, cfg_hub_func_ok_out, pme_active_out;
  logic [2:0] cfg_target_out;
  logic [5:0] owner_out, frame_done_out, cfg_hit_out;
  logic [7:0] irq_active_out, cfg_reg_addr_out;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  pha_bus_if bus_if_inst ();
  pha_host pha_host_inst (.clk_in, .resetn_in, .bus(bus_if_inst), .cfg_req_in, .cfg_addr_in, .cfg_busy_out,
    .cfg_target_out, .cfg_hub_func_ok_out, .owner_out, .irq_active_out, .pme_active_out);
  pha_slot pha_slot_inst (.clk_in, .resetn_in, .bus(bus_if_inst), .want_bus_in, .irq_in, .pme_in,
    .frame_done_out, .cfg_hit_out, .cfg_reg_addr_out);
  pha_assertions pha_assertions_inst (.clk_in, .resetn_in, .req_n_in(bus_if_inst.req_n),
    .gnt_n_in(bus_if_inst.gnt_n), .frame_n_in(bus_if_inst.frame_n), .ad_in(bus_if_inst.ad),
    .ad_oe_in(bus_if_inst.ad_oe), .cfg_cycle_in(bus_if_inst.cfg_cycle));
  // 100 MHz clock
  always #5 clk_in = ~clk_in;
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // all masters ask at once, then parking, owner restart and handover
  task automatic t_arb();
    logic [5:0] last;
    int k;
    last = 6'h0;
    k = 0;
    @(posedge clk_in);
    want_bus_in <= 6'h3F;
    for (int n = 0; n < 300 && k < 7; n++) begin
      @(negedge clk_in);
      if (owner_out != 6'h0 && owner_out != last) begin
        chk("grant_order", 32'(6'h1 << (k % 6)), 32'(owner_out));
        last = owner_out;
        k++;
      end
    end
    chk("grant_count", 32'd7, 32'(k));
    @(posedge clk_in);
    want_bus_in <= 6'h0;
    repeat (4) @(negedge clk_in);
    last = owner_out;
    repeat (10) @(negedge clk_in);
    chk("park_owner", 32'(last), 32'(owner_out));
    chk("park_held", 32'h1, 32'(last != 6'h0));
    @(posedge clk_in);
    want_bus_in <= last;
    k = 0;
    repeat (12) begin
      @(negedge clk_in);
      if (bus_if_inst.req_n !== 6'h3F) k = k + 100;
      if ((frame_done_out & last) != 6'h0) k++;
    end
    chk("owner_restart", 32'h1, 32'(k > 0 && k < 100));
    @(posedge clk_in);
    want_bus_in <= (last == 6'h01) ? 6'h02 : 6'h01;
    repeat (8) @(negedge clk_in);
    chk("new_owner", 32'((last == 6'h01) ? 6'h02 : 6'h01), 32'(owner_out));
    @(posedge clk_in);
    want_bus_in <= 6'h0;
    $display("t_arb done");
  endtask : t_arb
  // one config request; expected drive, target and slot hit
  task automatic cfg(input logic [31:0] a, input logic [31:0] ead, input logic [2:0] et, input logic [5:0] eh,
      input logic eo);
    @(posedge clk_in);
    cfg_req_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge clk_in);
    cfg_req_in <= 1'b0;
    @(negedge clk_in);
    chk("busy", 32'(a[31]), 32'(cfg_busy_out));
    if (a[31]) begin
      chk("ad", ead, bus_if_inst.ad);
      if (et != 3'h7) chk("target", 32'(et), 32'(cfg_target_out));
      if (et == 3'(PHA_TGT_HUB)) chk("hub_func", 32'(eo), 32'(cfg_hub_func_ok_out));
    end
    @(negedge clk_in);
    chk("busy_end", 32'h0, 32'(cfg_busy_out));
    if (eh != 6'h0) begin
      chk("slot_hit", 32'(eh), 32'(cfg_hit_out));
      chk("reg_addr", 32'({a[7:2], 2'b00}), 32'(cfg_reg_addr_out));
    end
  endtask : cfg
  // slot and board devices, hub functions, type 1, reserved type, disabled
  task automatic t_cfg();
    logic [4:0] sd [5] = '{5'h04, 5'h09, 5'h0A, 5'h0B, 5'h0D};
    int sl [5] = '{24, 25, 26, 27, 29};
    logic [4:0] od [5] = '{5'h00, 5'h01, 5'h02, 5'h1E, 5'h1F};
    pha_target_t ot [5] = '{PHA_TGT_MEMCTL, PHA_TGT_GFXBRIDGE, PHA_TGT_IGFX, PHA_TGT_P2P, PHA_TGT_HUB};
    logic [31:0] a;
    for (int k = 0; k < 5; k++) begin
      a = 32'h8000_0000 | (32'(sd[k]) << 11) | (32'(k) << 8) | (32'(k * 9 + 3) << 2);
      cfg(a, (32'h1 << sl[k]) | (a & 32'h7FC), PHA_TGT_SLOT, 6'(1 << k), 1'b0);
      a = 32'h8000_0000 | (32'(od[k]) << 11) | (32'(k + 40) << 2);
      cfg(a, a & 32'h7FC, ot[k], 6'h0, 1'b1);
    end
    for (int f = 0; f < 8; f++) begin
      a = 32'h8000_F800 | (32'(f) << 8);
      cfg(a, a & 32'h7FC, PHA_TGT_HUB, 6'h0, f inside {0, 1, 3, 4, 5});
    end
    cfg(32'h8000_2810, 32'h0000_0010, PHA_TGT_NONE, 6'h0, 1'b0);
    cfg(32'h80A5_6F15, 32'h00A5_6F15, 3'h7, 6'h0, 1'b0);
    cfg(32'h8000_2006, 32'h0, PHA_TGT_NONE, 6'h0, 1'b0);
    cfg(32'h0000_2004, 32'h0, 3'h7, 6'h0, 1'b0);
    cfg(32'h8002_2008, 32'h0100_0008, PHA_TGT_SLOT, 6'h01, 1'b0);
    cfg(32'h8002_0808, 32'h0000_0008, PHA_TGT_NONE, 6'h00, 1'b0);
    $display("t_cfg done");
  endtask : t_cfg
  // interrupt and wake levels pass through with their polarity
  task automatic t_irq();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      irq_in <= k ? 8'h5A : 8'hA5;
      pme_in <= !k;
      repeat (4) @(negedge clk_in);
      chk("irq", k ? 32'h5A : 32'hA5, 32'(irq_active_out));
      chk("pme", 32'(!k), 32'(pme_active_out));
    end
    $display("t_irq done");
  endtask : t_irq
  // main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(negedge clk_in);
    chk("reset_owner", 32'h0, 32'(owner_out));
    chk("reset_gnt", 32'h3F, 32'(bus_if_inst.gnt_n));
    t_arb();
    t_cfg();
    t_irq();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
